//--- core/gpio_ports.sv
// General-purpose ports with direction control, wake-up and shared timer pins.
//
// Overview of operation
// - Direction bit 1 makes the pin input; 0 drives it as output.
// - Every pin has its own direction bit.
// - Input pins are not latched; reads sample the live pin level.
// - Written data stays in the output latch until rewritten.
// - Reading an output pin returns the output latch, not the pin.
// - Reset sets all data and direction registers to all ones.
// - Bit set or clear is a read of the port then a full write-back.
// - In power-down, a falling edge on a selected wake-up pin wakes the device.
// - Wake-up is chosen per bit on some pins, per nibble on others.
// - Weak pull-up only on input pins and only where configuration enables it.
// - Each port A pin is push-pull, open-drain, or pull-up-only by configuration.
// - Port A bit 6 feeds the 8-bit timer clock in external-input modes.
// - Port A bit 7 feeds the 16-bit timer clock in external-input modes.
// - In event mode each selected edge on the timer pin counts one.
// - Halt enters power-down until a wake-up event.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module gpio_ports #(
  parameter int unsigned NPORT = gpio_pkg::NUM_PORTS,
  parameter int unsigned W     = gpio_pkg::PORT_W
) (
  // Clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  // Register port
  input  wire logic [gpio_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [W-1:0]               wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [W-1:0]               rdata_o,
  // Configuration options
  input  wire logic [NPORT*W-1:0]         wake_bit_en_i,
  input  wire logic [NPORT*W-1:0]         wake_bit_mode_i,
  input  wire logic [NPORT*2-1:0]         wake_nib_en_i,
  input  wire logic [NPORT*W-1:0]         pullup_en_i,
  input  wire logic [2*W-1:0]             port_a_structure_i,
  // Pins
  input  wire logic [NPORT*W-1:0]         pin_i,
  output logic      [NPORT*W-1:0]         pin_o,
  output logic      [NPORT*W-1:0]         pin_oe_n_o,
  output logic      [NPORT*W-1:0]         pullup_o,
  // Power and timer events
  input  wire logic                       halt_i,
  output logic                            power_down_o,
  output logic                            wake_o,
  output logic                            timer8_count_o,
  output logic                            timer16_count_o,
  output logic                            irq_o
);
  import gpio_pkg::*;

  logic [W-1:0]         data_q [NPORT];
  logic [W-1:0]         dir_q  [NPORT];
  logic [W-1:0]         t8_ctrl_q;
  logic [W-1:0]         t16_ctrl_q;
  logic [IRQ_W-1:0]     irq_stat_q;
  logic [IRQ_W-1:0]     irq_en_q;
  logic [NPORT*W-1:0]   sync1_q;
  logic [NPORT*W-1:0]   sync2_q;
  logic [NPORT*W-1:0]   prev_q;
  logic [NPORT*W-1:0]   fall_sel;
  logic [NPORT*W-1:0]   wake_sel;
  logic [NPORT*W-1:0]   dir_flat;
  logic [NPORT*W-1:0]   data_flat;
  pwr_state_t           pwr_q;
  logic                 any_wake;
  logic                 t8_edge;
  logic                 t16_edge;
  logic [IRQ_W-1:0]     irq_set;
  logic [2:0]           prime_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1_q <= '1;
      sync2_q <= '1;
      prev_q  <= '1;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Edges are ignored until the pipeline holds real pin levels, so a pin that idles low
  // does not look like a falling edge right after reset.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prime_q <= '0;
    end else begin
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // Wake-up selection is per bit, or per nibble where the bit option selects nibble mode.
  genvar gi;
  generate
    for (gi = 0; gi < NPORT*W; gi++) begin : g_pin
      assign wake_sel[gi] = wake_bit_mode_i[gi] ? wake_nib_en_i[gi/4]
                                                : wake_bit_en_i[gi];
      assign fall_sel[gi] = prime_q[2] & wake_sel[gi] & prev_q[gi] & ~sync2_q[gi];
      assign dir_flat[gi]  = dir_q[gi/W][gi%W];
      assign data_flat[gi] = data_q[gi/W][gi%W];
    end
  endgenerate

  assign any_wake = |fall_sel;

  // The timer pins only count when the timer mode selects the external input.
  assign t8_edge  = prime_q[2] && (t8_ctrl_q[TMODE_HI:TMODE_LO] != TMODE_TIMER) &&
                    (t8_ctrl_q[TEDGE_BIT] ? (~prev_q[6] & sync2_q[6])
                                          : (prev_q[6] & ~sync2_q[6]));
  assign t16_edge = prime_q[2] && (t16_ctrl_q[TMODE_HI:TMODE_LO] != TMODE_TIMER) &&
                    (t16_ctrl_q[TEDGE_BIT] ? (~prev_q[7] & sync2_q[7])
                                           : (prev_q[7] & ~sync2_q[7]));

  ////////////////////////////////////////////////////////////////////////////
  // Port data and direction latches.

  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          data_q[gi] <= DATA_RST;
          dir_q[gi]  <= DIR_RST;
        end else if (wr_i) begin
          // A bit operation arrives here as a full byte write-back of the read value.
          if (addr_i == PORT_A_DATA + 4'(gi)) begin
            data_q[gi] <= wdata_i;
          end
          if (addr_i == PORT_A_DIRECTION + 4'(gi)) begin
            dir_q[gi] <= wdata_i;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Timer control and interrupt registers.

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      t8_ctrl_q  <= TCTRL_RST;
      t16_ctrl_q <= TCTRL_RST;
      irq_en_q   <= '0;
    end else if (wr_i) begin
      if (addr_i == TIMER8_CONTROL) begin
        t8_ctrl_q <= wdata_i;
      end
      if (addr_i == TIMER16_CONTROL) begin
        t16_ctrl_q <= wdata_i;
      end
      if (addr_i == IRQ_ENABLE) begin
        irq_en_q <= wdata_i[IRQ_W-1:0];
      end
    end
  end

  assign irq_set = {t16_edge, t8_edge, any_wake};

  // A new event in the clearing cycle wins over the clear.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else if (wr_i && addr_i == IRQ_CLEAR) begin
      irq_stat_q <= (irq_stat_q & ~wdata_i[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_stat_q | irq_set) & irq_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down control.

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pwr_q  <= PWR_RUN;
      wake_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      case (pwr_q)
        PWR_RUN: begin
          if (halt_i) begin
            pwr_q <= PWR_DOWN;
          end
        end
        PWR_DOWN: begin
          if (any_wake) begin
            pwr_q  <= PWR_RUN;
            wake_o <= 1'b1;
          end
        end
        default: pwr_q <= PWR_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      power_down_o <= 1'b0;
    end else begin
      power_down_o <= (pwr_q == PWR_RUN) ? halt_i : !any_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= '0;
      for (int p = 0; p < NPORT; p++) begin
        if (addr_i == PORT_A_DATA + 4'(p)) begin
          // Inputs give the raw pin level, outputs the latch.
          rdata_o <= (dir_q[p] & pin_i[p*W +: W]) | (~dir_q[p] & data_q[p]);
        end
        if (addr_i == PORT_A_DIRECTION + 4'(p)) begin
          rdata_o <= dir_q[p];
        end
      end
      if (addr_i == TIMER8_CONTROL) begin
        rdata_o <= t8_ctrl_q;
      end
      if (addr_i == TIMER16_CONTROL) begin
        rdata_o <= t16_ctrl_q;
      end
      if (addr_i == IRQ_STATUS) begin
        rdata_o <= {{(W-IRQ_W){1'b0}}, irq_stat_q};
      end
      if (addr_i == IRQ_ENABLE) begin
        rdata_o <= {{(W-IRQ_W){1'b0}}, irq_en_q};
      end
      if (addr_i == POWER_CONTROL) begin
        rdata_o <= {{(W-1){1'b0}}, pwr_q == PWR_DOWN};
      end
    end else begin
      rdata_o <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers.

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_o      <= '1;
      pin_oe_n_o <= '1;
      pullup_o   <= '0;
    end else begin
      for (int b = 0; b < NPORT*W; b++) begin
        pin_o[b]      <= data_flat[b];
        pin_oe_n_o[b] <= dir_flat[b];
        pullup_o[b]   <= dir_flat[b] & pullup_en_i[b];
      end
      // Open-drain drives only low, pull-up-only drives only high; these override the above.
      for (int b = 0; b < W; b++) begin
        if (port_a_structure_i[2*b +: 2] == OUT_OPEN_DRAIN) begin
          pin_oe_n_o[b] <= dir_flat[b] | data_flat[b];
        end else if (port_a_structure_i[2*b +: 2] == OUT_PULL_UP_ONLY) begin
          pin_oe_n_o[b] <= dir_flat[b] | ~data_flat[b];
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      timer8_count_o  <= 1'b0;
      timer16_count_o <= 1'b0;
    end else begin
      timer8_count_o  <= t8_edge;
      timer16_count_o <= t16_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  reset_dir_a: assert property (@(posedge mclk_i) rst_i |=> pin_oe_n_o == '1)
    else $error("pins not inputs after reset");
  dir_drive_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (dir_q[1][0] == 1'b0) |=> (pin_oe_n_o[W] == 1'b0))
    else $error("output pin not driven");
  latch_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(wr_i && addr_i == PORT_A_DATA) |=> $stable(data_q[0]))
    else $error("latch changed without write");
  out_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_i && addr_i == PORT_B_DATA && dir_q[1] == 8'h00) |=> rdata_o == $past(data_q[1]))
    else $error("output read not latch");
  in_read_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_i && addr_i == PORT_C_DATA && dir_q[2] == 8'hFF) |=> rdata_o == $past(pin_i[23:16]))
    else $error("input read not live pin");
  wake_exit_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pwr_q == PWR_DOWN && any_wake) |=> (pwr_q == PWR_RUN && wake_o))
    else $error("no wake on falling edge");
  wake_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    irq_set[IRQ_WAKE] |=> irq_stat_q[IRQ_WAKE])
    else $error("wake status lost to clear");
  halt_enter_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pwr_q == PWR_RUN && halt_i) |=> power_down_o ##0 pwr_q == PWR_DOWN)
    else $error("halt did not power down");
  pullup_in_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    pullup_o[3] |-> $past(dir_flat[3] & pullup_en_i[3]))
    else $error("pull-up on output pin");
  od_drive_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (port_a_structure_i[3:2] == OUT_OPEN_DRAIN && data_q[0][1]) |=> pin_oe_n_o[1])
    else $error("open-drain pin driven high");
  t8_count_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer8_count_o |-> $past(t8_ctrl_q[TMODE_HI:TMODE_LO]) != TMODE_TIMER)
    else $error("timer pin counted in timer mode");
  t16_count_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer16_count_o |-> $past(t16_ctrl_q[TMODE_HI:TMODE_LO]) != TMODE_TIMER)
    else $error("wide timer pin counted in timer mode");
  sync_fall_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    fall_sel[0] |-> $past(pin_i[0], 3) && !$past(pin_i[0], 2))
    else $error("wake edge not from synchronised pin");

  wake_cov_c:  cover property (@(posedge mclk_i) pwr_q == PWR_DOWN ##1 wake_o);
  t16_cov_c:   cover property (@(posedge mclk_i) timer16_count_o);
  irq_cov_c:   cover property (@(posedge mclk_i) irq_o);
  rmw_cov_c:   cover property (@(posedge mclk_i) rd_i && addr_i == PORT_A_DATA ##1
                               wr_i && addr_i == PORT_A_DATA);

endmodule

//--- core/gpio_pkg.sv
// Package of constants for the general-purpose port block with wake-up.
package gpio_pkg;

  localparam int unsigned NUM_PORTS  = 5;
  localparam int unsigned PORT_W     = 8;
  localparam int unsigned ADDR_W     = 4;

  // Register offsets: data and direction of ports A to E, then the block's own registers.
  localparam logic [3:0] PORT_A_DATA      = 4'h0;
  localparam logic [3:0] PORT_B_DATA      = 4'h1;
  localparam logic [3:0] PORT_C_DATA      = 4'h2;
  localparam logic [3:0] PORT_D_DATA      = 4'h3;
  localparam logic [3:0] PORT_E_DATA      = 4'h4;
  localparam logic [3:0] PORT_A_DIRECTION = 4'h5;
  localparam logic [3:0] PORT_E_DIRECTION = 4'h9;
  localparam logic [3:0] TIMER8_CONTROL   = 4'hA;
  localparam logic [3:0] TIMER16_CONTROL  = 4'hB;
  localparam logic [3:0] IRQ_STATUS       = 4'hC;
  localparam logic [3:0] IRQ_ENABLE       = 4'hD;
  localparam logic [3:0] IRQ_CLEAR        = 4'hE;
  localparam logic [3:0] POWER_CONTROL    = 4'hF;

  // Reset values: every data latch and direction bit high.
  localparam logic [7:0] DATA_RST         = 8'hFF;
  localparam logic [7:0] DIR_RST          = 8'hFF;
  localparam logic [7:0] TCTRL_RST        = 8'h00;

  // Timer control fields: mode pair in bits 7:6, edge select in bit 3.
  localparam int unsigned TMODE_HI        = 7;
  localparam int unsigned TMODE_LO        = 6;
  localparam int unsigned TEDGE_BIT       = 3;
  localparam logic [1:0]  TMODE_EVENT     = 2'h0;
  localparam logic [1:0]  TMODE_TIMER     = 2'h2;
  localparam logic [1:0]  TMODE_PULSE     = 2'h1;

  // Interrupt status bits.
  localparam int unsigned IRQ_WAKE        = 0;
  localparam int unsigned IRQ_T8_EDGE     = 1;
  localparam int unsigned IRQ_T16_EDGE    = 2;
  localparam int unsigned IRQ_W           = 3;

  // Port A output structure codes.
  localparam logic [1:0] OUT_PUSH_PULL    = 2'h0;
  localparam logic [1:0] OUT_OPEN_DRAIN   = 2'h1;
  localparam logic [1:0] OUT_PULL_UP_ONLY = 2'h2;

  typedef enum logic [0:0] {
    PWR_RUN  = 1'b0,
    PWR_DOWN = 1'b1
  } pwr_state_t;

endpackage

//--- dv/pin_world.sv
// External circuitry on the port pins: switches, weak pull-ups and floating lines.
`timescale 1ns/10ps
module pin_world (
  // Clock
  input  wire logic        mclk_i,
  // Device drive
  input  wire logic [39:0] dout_i,
  input  wire logic [39:0] oe_n_i,
  input  wire logic [39:0] pullup_i,
  // Switches
  input  wire logic [39:0] ext_v_i,
  input  wire logic [39:0] ext_e_i,
  // Resolved level
  output logic      [39:0] lvl_o
);
  logic [39:0] wig_q = 40'h5A_A55A_A55A;

  // Undriven lines with no pull-up toggle every cycle so that a read of a floating pin never matches by luck.
  always_ff @(posedge mclk_i) begin
    wig_q <= ~wig_q;
  end

  assign lvl_o = (~oe_n_i & dout_i) | (oe_n_i & ext_e_i & ext_v_i)
               | (oe_n_i & ~ext_e_i & (pullup_i | wig_q));
endmodule

//--- dv/gpio_ports_with_wakeup_bench.sv
// Self-checking bench for the general-purpose ports with wake-up.
`timescale 1ns/10ps
module gpio_ports_with_wakeup_bench;
  import gpio_pkg::*;
  logic        mclk_i, rst_i, wr_i, rd_i, halt_i;
  logic [3:0]  addr_i;
  logic [7:0]  wdata_i, rdata_o, v, m, dirs [5], dats [5];
  logic [15:0] pstruct;
  logic [39:0] wben, wbmode, pullen, pin_lvl, pin_o, oe_n, pu, ext_v, ext_e, dcat;
  logic [9:0]  nben;
  logic        pd_o, wake_o, t8_o, t16_o, irq_o;
  int          n_fail, samples_checked;
  logic [31:0] lfsr_q = 32'h784B;

  gpio_ports u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wake_bit_en_i(wben),
    .wake_bit_mode_i(wbmode), .wake_nib_en_i(nben), .pullup_en_i(pullen),
    .port_a_structure_i(pstruct), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_n_o(oe_n),
    .pullup_o(pu), .halt_i(halt_i), .power_down_o(pd_o), .wake_o(wake_o),
    .timer8_count_o(t8_o), .timer16_count_o(t16_o), .irq_o(irq_o));
  pin_world u_pins (.mclk_i(mclk_i), .dout_i(pin_o), .oe_n_i(oe_n), .pullup_i(pu),
    .ext_v_i(ext_v), .ext_e_i(ext_e), .lvl_o(pin_lvl));

  function automatic logic [7:0] rnd8();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[7:0];
  endfunction

  // Inputs read the pin, outputs read the latch.
  function automatic logic [7:0] exp_port(input logic [7:0] dir, input logic [7:0] pin,
                                          input logic [7:0] lat);
    return (dir & pin) | (~dir & lat);
  endfunction

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // Waits a bounded eight cycles for a pulse on the selected output.
  task automatic pulse(input int sel, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge mclk_i);
      #1 seen |= (sel == 0) ? t8_o : (sel == 1) ? t16_o : wake_o;
    end
    chk({39'h0, seen}, {39'h0, exp});
  endtask

  task automatic final_report();
    $display("checked=%0d failures=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (60000) @(posedge mclk_i);
    n_fail++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0; samples_checked = 0;
    rst_i = 1'b1; wr_i = 1'b0; rd_i = 1'b0; halt_i = 1'b0; addr_i = 4'h0; wdata_i = 8'h00;
    wben = '0; wbmode = '0; nben = '0; pullen = '1; ext_v = '1; ext_e = '1;
    pstruct = '0;
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1 chk(oe_n, '1);
    chk(pin_o, '1);
    for (int p = 0; p < 5; p++) begin
      rd(4'(PORT_A_DIRECTION + p), v);
      chk(v, 8'hFF);
    end
    // Both timer pins count on the chosen edge in event mode, never in timer mode.
    for (int t = 0; t < 2; t++) begin
      for (int e = 0; e < 2; e++) begin
        wr(4'(TIMER8_CONTROL + t), 8'(e << 3));
        ext_v[6+t] <= ~e[0];
        repeat (6) @(posedge mclk_i);
        ext_v[6+t] <= e[0];
        pulse(t, 1'b1);
        ext_v[6+t] <= ~e[0];
        pulse(t, 1'b0);
      end
      wr(4'(TIMER8_CONTROL + t), 8'h80);
      ext_v[6+t] <= 1'b1;
      repeat (6) @(posedge mclk_i);
      ext_v[6+t] <= 1'b0;
      pulse(t, 1'b0);
      ext_v[6+t] <= 1'b1;
    end
    // Random data on every port with direction 0F, 00, FF, then random; then live reads.
    for (int n = 0; n < 6; n++) begin
      pullen <= {rnd8(), rnd8(), rnd8(), rnd8(), rnd8()};
      for (int p = 0; p < 5; p++) begin
        dats[p] = rnd8();
        dirs[p] = (n == 0) ? 8'h0F : (n == 1) ? 8'h00 : (n == 2) ? 8'hFF : rnd8();
        wr(4'(PORT_A_DATA + p), dats[p]);
        wr(4'(PORT_A_DIRECTION + p), dirs[p]);
      end
      dcat = {dirs[4], dirs[3], dirs[2], dirs[1], dirs[0]};
      ext_v <= {rnd8(), rnd8(), rnd8(), rnd8(), rnd8()};
      repeat (3) @(posedge mclk_i);
      #1 chk(oe_n, dcat);
      chk(pu, pullen & dcat);
      chk(pin_o & ~dcat, {dats[4], dats[3], dats[2], dats[1], dats[0]} & ~dcat);
      for (int p = 0; p < 5; p++) begin
        rd(4'(PORT_A_DATA + p), v);
        chk(v, exp_port(dirs[p], ext_v[p*8+:8], dats[p]));
      end
      // Single-bit change done as read, modify, full write-back; input bits take the pin level.
      m = 8'h01 << (rnd8() % 8);
      rd(PORT_A_DATA, v);
      wr(PORT_A_DATA, v ^ m);
      repeat (3) @(posedge mclk_i);
      #1 chk(pin_o[7:0], exp_port(dirs[0], ext_v[7:0], dats[0]) ^ m);
    end
    // Port A as outputs: open-drain on the low nibble, pull-up-only on the high nibble.
    pstruct <= 16'hAA55;
    wr(PORT_A_DATA, 8'h5A);
    wr(PORT_A_DIRECTION, 8'h00);
    repeat (3) @(posedge mclk_i);
    #1 chk(oe_n[7:0], 8'hAA);
    for (int p = 0; p < 5; p++) begin
      wr(4'(PORT_A_DIRECTION + p), 8'hFF);
    end
    ext_v <= '1;
    wr(IRQ_CLEAR, 8'h07);
    // Wake from power-down: by bit on pin 0, by nibble on pin 8.
    for (int k = 0; k < 2; k++) begin
      wben <= (k == 0) ? 40'h1 : 40'h0;
      wbmode <= (k == 0) ? 40'h0 : 40'h100;
      nben <= (k == 0) ? 10'h0 : 10'h004;
      repeat (4) @(posedge mclk_i);
      halt_i <= 1'b1;
      @(posedge mclk_i);
      halt_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      ext_v[k*8] <= 1'b0;
      #1 chk(pd_o, 1'b1);
      pulse(2, 1'b1);
      chk(pd_o, 1'b0);
      chk(irq_o, 1'b0);
      rd(IRQ_STATUS, v);
      chk(v, 8'h01);
      wr(IRQ_ENABLE, 8'h01);
      repeat (2) @(posedge mclk_i);
      #1 chk(irq_o, 1'b1);
      ext_v[k*8] <= 1'b1;
      wr(IRQ_CLEAR, 8'h01);
      repeat (2) @(posedge mclk_i);
      #1 chk(irq_o, 1'b0);
      wr(IRQ_ENABLE, 8'h00);
    end
    final_report();
  end
endmodule
